// ==== logic/tccp_defs.svh ====
// named constants for the timer capture/compare and pulse generator block
`ifndef TCCP_DEFS_SVH
`define TCCP_DEFS_SVH

// ----------------------------------------
// operating mode field codes
// ----------------------------------------
`define TCCP_MODE_STOP 2'h0
`define TCCP_MODE_FREE 2'h1
`define TCCP_MODE_CLR_TRIG 2'h2
`define TCCP_MODE_PPG 2'h3

// ----------------------------------------
// valid-edge select codes
// ----------------------------------------
`define TCCP_EDGE_FALL 2'h0
`define TCCP_EDGE_RISE 2'h1
`define TCCP_EDGE_NONE 2'h2
`define TCCP_EDGE_BOTH 2'h3

// ----------------------------------------
// output-toggle select codes {toggle_on_match_b, toggle_on_match_a}
// ----------------------------------------
`define TCCP_TOG_OFF 2'h0
`define TCCP_TOG_A 2'h1
`define TCCP_TOG_B 2'h2
`define TCCP_TOG_EITHER 2'h3

// ----------------------------------------
// reset values, levels, trigger select and width limits
// ----------------------------------------
`define TCCP_OUT_INACTIVE 1'b0
`define TCCP_OUT_ACTIVE 1'b1
`define TCCP_FLAG_CLEAR 1'b0
`define TCCP_TRIG_SEL_B 1'b0
`define TCCP_MIN_CNT_W 2
`define TCCP_MAX_CNT_W 32

`endif

// ==== logic/tccp_pkg.sv ====
// types shared by the timer capture/compare block
package tccp_pkg;
   typedef logic [1:0] tccp_mode_t;
   typedef logic [1:0] tccp_edge_sel_t;
   typedef logic [1:0] tccp_tog_sel_t;
endpackage : tccp_pkg

// ==== logic/tccp_edge_det.sv ====
// valid-edge and reverse-edge detector for one trigger pin
`timescale 1ns/1ps
`include "tccp_defs.svh"

module tccp_edge_det (
   input wire logic clock,
   input wire logic resetn,
   input wire logic pin,
   input wire tccp_pkg::tccp_edge_sel_t edge_sel,
   output logic valid_edge,
   output logic reverse_edge
);
   logic prev_q;
   logic rise;
   logic fall;
   logic sel_rise;
   logic sel_fall;
   logic sel_both;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= pin;
      end
   end

   assign rise = pin & ~prev_q;
   assign fall = ~pin & prev_q;
   assign sel_rise = (edge_sel == `TCCP_EDGE_RISE);
   assign sel_fall = (edge_sel == `TCCP_EDGE_FALL);
   assign sel_both = (edge_sel == `TCCP_EDGE_BOTH);
   assign valid_edge = (sel_rise & rise) | (sel_fall & fall) | (sel_both & (rise | fall));
   // opposite phase only exists for a single-edge selection
   assign reverse_edge = (sel_rise & fall) | (sel_fall & rise);
endmodule : tccp_edge_det

// ==== logic/tccp_cc_reg.sv ====
// one capture/compare register: software load or hardware capture
`timescale 1ns/1ps

module tccp_cc_reg #(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [CNT_W-1:0] wr_data,
   input wire logic capture,
   input wire logic [CNT_W-1:0] count,
   output logic [CNT_W-1:0] value_q
);
   logic [CNT_W-1:0] value_d;

   // a capture beats a software write landing in the same cycle
   assign value_d = capture ? count : (wr_en ? wr_data : value_q);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         value_q <= '0;
      end else begin
         value_q <= value_d;
      end
   end
endmodule : tccp_cc_reg

// ==== logic/tccp_timer.sv ====
// 16-bit up counter with two capture/compare registers and pulse output
`timescale 1ns/1ps
`include "tccp_defs.svh"

// Function
// - compare match of register A raises match_irq_a; counter not cleared outside PROGRAMMABLE_PULSE_MODE.
// - register A captures count on trigger_in_b edge or trigger_in_a, selectable.
// - timer_out unavailable while trigger_in_b edge detection feeds register A.
// - compare match of register B raises match_irq_b; counter not cleared.
// - register B captures count only on trigger_in_a valid edges.
// - mode 01 free-running, 10 clear on trigger_in_a edge, 11 PROGRAMMABLE_PULSE_MODE.
// - free-running counter wraps FFFFH to 0000H, setting overflow_flag, keeps counting.
// - overflow_flag stays set until software clears it by writing 0.
// - free-running supports compare/compare, compare/capture and capture/capture setups.
// - both compare: timer_out toggles on each match, each raising its interrupt.
// - register B capturing: trigger_in_a edge captures into B and raises match_irq_b.
// - both capturing: no toggle unless out_toggle_on_edge, then toggle on trigger_in_a.
// - both capturing: trigger_in_a edge loads B, trigger_in_b edge loads A.
// - trigger_in_b edges never load B; both trigger_in_b edges may capture into A.
// - toggle select 10 toggles on B match, 11 on either match.
// - PROGRAMMABLE_PULSE_MODE period is register A plus one count clocks.
// - PROGRAMMABLE_PULSE_MODE active width is register B plus one count clocks.
// - PROGRAMMABLE_PULSE_MODE match with A raises match_irq_a and clears the counter.
// - counter value readable any time without disturbing counting.
// - clear-on-trigger mode clears counter to 0000H on trigger_in_a valid edge.
module tccp_timer #(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic count_tick,
   input wire tccp_pkg::tccp_mode_t op_mode,
   input wire logic cc_a_is_capture,
   input wire logic cc_b_is_capture,
   input wire logic cc_a_trig_sel,
   input wire tccp_pkg::tccp_edge_sel_t trig_a_edge_sel,
   input wire tccp_pkg::tccp_edge_sel_t trig_b_edge_sel,
   input wire logic trigger_in_a,
   input wire logic trigger_in_b,
   input wire logic out_toggle_on_edge,
   input wire logic out_enable,
   input wire logic toggle_on_match_a,
   input wire logic toggle_on_match_b,
   input wire logic out_level_set,
   input wire logic out_level_reset,
   input wire logic cc_a_wr,
   input wire logic [CNT_W-1:0] cc_a_wdata,
   input wire logic cc_b_wr,
   input wire logic [CNT_W-1:0] cc_b_wdata,
   input wire logic overflow_clear,
   output logic [CNT_W-1:0] count_reg,
   output logic [CNT_W-1:0] capture_compare_a,
   output logic [CNT_W-1:0] capture_compare_b,
   output logic match_irq_a,
   output logic match_irq_b,
   output logic overflow_flag,
   output logic timer_out
);
   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   generate
      if (CNT_W < `TCCP_MIN_CNT_W || CNT_W > `TCCP_MAX_CNT_W) begin : g_bad_width
         $error("tccp_timer: CNT_W out of range");
      end
   endgenerate

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic tog_hit(input tccp_pkg::tccp_tog_sel_t sel, input logic ma,
                                    input logic mb);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         `TCCP_TOG_OFF: hit = 1'b0;
         `TCCP_TOG_A: hit = ma;
         `TCCP_TOG_B: hit = mb;
         `TCCP_TOG_EITHER: hit = ma | mb;
      endcase
      return hit;
   endfunction : tog_hit

   function automatic logic mode_is(input tccp_pkg::tccp_mode_t m,
                                    input tccp_pkg::tccp_mode_t code);
      return m == code;
   endfunction : mode_is

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic overflow_q;
   logic overflow_d;
   logic irq_a_q;
   logic irq_a_d;
   logic irq_b_q;
   logic irq_b_d;
   logic out_q;
   logic out_d;

   // ----------------------------------------
   // trigger edge detection
   // ----------------------------------------
   logic a_valid;
   logic a_reverse;
   logic b_valid;

   tccp_edge_det u_edge_a (
      .clock(clock),
      .resetn(resetn),
      .pin(trigger_in_a),
      .edge_sel(trig_a_edge_sel),
      .valid_edge(a_valid),
      .reverse_edge(a_reverse)
   );

   // both-edge selection lets register A see each trigger_in_b transition
   tccp_edge_det u_edge_b (
      .clock(clock),
      .resetn(resetn),
      .pin(trigger_in_b),
      .edge_sel(trig_b_edge_sel),
      .valid_edge(b_valid),
      .reverse_edge()
   );

   // ----------------------------------------
   // capture trigger routing
   // ----------------------------------------
   // trigger_in_b reaches only register A, and then costs the output pin
   logic a_from_b;

   assign a_from_b = (cc_a_trig_sel == `TCCP_TRIG_SEL_B);

   // ----------------------------------------
   // mode and event decode
   // ----------------------------------------
   logic counting;
   logic programmable_pulse_mode;
   logic clr_trig_mode;
   logic tick;
   logic match_a;
   logic match_b;
   logic cap_a;
   logic cap_b;
   logic b_in_use;
   logic clear_on_trig;
   logic ppg_restart;
   logic wrap;
   logic tog_match;
   logic tog_edge;
   logic out_blocked;
   logic [CNT_W-1:0] count_max;

   assign count_max = '1;
   assign counting = !mode_is(op_mode, `TCCP_MODE_STOP);
   assign programmable_pulse_mode = mode_is(op_mode, `TCCP_MODE_PPG);
   assign clr_trig_mode = mode_is(op_mode, `TCCP_MODE_CLR_TRIG);
   assign tick = counting & count_tick;

   // a match counts only on the tick that leaves the matching value
   assign match_a = tick & ~cc_a_is_capture & (count_q == capture_compare_a);
   assign match_b = tick & ~cc_b_is_capture & (count_q == capture_compare_b);

   // register A: trigger_in_b valid edge, or opposite phase of trigger_in_a
   assign cap_a = counting & cc_a_is_capture
                  & (a_from_b ? b_valid : a_reverse);
   // register B only ever listens to trigger_in_a
   assign cap_b = counting & cc_b_is_capture & a_valid;

   assign b_in_use = cc_a_is_capture & a_from_b;
   assign clear_on_trig = clr_trig_mode & a_valid;
   assign ppg_restart = programmable_pulse_mode & match_a;
   assign wrap = tick & ~ppg_restart & ~clear_on_trig & (count_q == count_max);

   // ----------------------------------------
   // counter next value
   // ----------------------------------------
   // capture samples count_q before any clear, so the stored value is the old count
   assign count_d = !counting ? '0
                  : clear_on_trig ? '0
                  : ppg_restart ? '0
                  : tick ? count_q + 1'b1
                  : count_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   // counter is a plain register tap; reading it has no side effect
   assign count_reg = count_q;

   // ----------------------------------------
   // capture/compare registers
   // ----------------------------------------
   // software loads only reach a register in compare use
   tccp_cc_reg #(
      .CNT_W(CNT_W)
   ) u_cc_a (
      .clock(clock),
      .resetn(resetn),
      .wr_en(cc_a_wr & ~cc_a_is_capture),
      .wr_data(cc_a_wdata),
      .capture(cap_a),
      .count(count_q),
      .value_q(capture_compare_a)
   );

   tccp_cc_reg #(
      .CNT_W(CNT_W)
   ) u_cc_b (
      .clock(clock),
      .resetn(resetn),
      .wr_en(cc_b_wr & ~cc_b_is_capture),
      .wr_data(cc_b_wdata),
      .capture(cap_b),
      .count(count_q),
      .value_q(capture_compare_b)
   );

   // ----------------------------------------
   // interrupts and overflow
   // ----------------------------------------
   // reverse-phase capture into A raises no interrupt
   assign irq_a_d = match_a | (cap_a & a_from_b);
   assign irq_b_d = match_b | cap_b;
   // a wrap in the clearing cycle still sets the flag
   assign overflow_d = wrap | (overflow_q & ~overflow_clear);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_a_q <= 1'b0;
      end else begin
         irq_a_q <= irq_a_d;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_b_q <= 1'b0;
      end else begin
         irq_b_q <= irq_b_d;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         overflow_q <= `TCCP_FLAG_CLEAR;
      end else begin
         overflow_q <= overflow_d;
      end
   end

   assign match_irq_a = irq_a_q;
   assign match_irq_b = irq_b_q;
   assign overflow_flag = overflow_q;

   // ----------------------------------------
   // timer output
   // ----------------------------------------
   assign tog_match = tog_hit({toggle_on_match_b, toggle_on_match_a}, match_a, match_b);
   // with both in capture the compare matches are gated off, leaving the edge toggle
   assign tog_edge = counting & out_toggle_on_edge & a_valid;
   // trigger_in_b detection shares the output path, so the pin is held inactive
   assign out_blocked = ~out_enable | b_in_use;

   always_comb begin
      out_d = out_q;
      if (out_blocked) begin
         out_d = `TCCP_OUT_INACTIVE;
      end else if (out_level_set) begin
         out_d = `TCCP_OUT_ACTIVE;
      end else if (out_level_reset) begin
         out_d = `TCCP_OUT_INACTIVE;
      end else if (programmable_pulse_mode) begin
         // active from count 0 through B, inactive after B until A restarts
         if (match_a) begin
            out_d = `TCCP_OUT_ACTIVE;
         end else if (match_b) begin
            out_d = `TCCP_OUT_INACTIVE;
         end
      end else if (tog_match | tog_edge) begin
         out_d = ~out_q;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         out_q <= `TCCP_OUT_INACTIVE;
      end else begin
         out_q <= out_d;
      end
   end

   assign timer_out = out_q;
endmodule : tccp_timer

// ==== sim/tccp_timer_assertions.sv ====
// port checks for the timer block
`timescale 1ns/1ps
module tccp_timer_assertions #(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic count_tick,
   input wire tccp_pkg::tccp_mode_t op_mode,
   input wire logic cc_a_is_capture,
   input wire logic cc_b_is_capture,
   input wire tccp_pkg::tccp_edge_sel_t trig_a_edge_sel,
   input wire logic trigger_in_a,
   input wire logic overflow_clear,
   input wire logic [CNT_W-1:0] count_reg,
   input wire logic [CNT_W-1:0] capture_compare_a,
   input wire logic [CNT_W-1:0] capture_compare_b,
   input wire logic match_irq_a,
   input wire logic match_irq_b,
   input wire logic overflow_flag,
   input wire logic timer_out
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // a match only counts on a live tick
   wire logic run = count_tick && op_mode != 2'h0;
   wire logic hit_a = run && !cc_a_is_capture && count_reg == capture_compare_a;
   wire logic hit_b = run && !cc_b_is_capture && count_reg == capture_compare_b;
   irq_a_match_a: assert property (hit_a |=> match_irq_a) else $error("A irq");
   irq_b_match_a: assert property (hit_b |=> match_irq_b) else $error("B irq");
   count_step_a: assert property (run && op_mode == 2'h1 |=>
      count_reg == CNT_W'($past(count_reg) + 1)) else $error("count step");
   wrap_flag_a: assert property (run && op_mode == 2'h1 && &count_reg |=>
      overflow_flag && count_reg == '0) else $error("wrap");
   flag_sticky_a: assert property (overflow_flag && !overflow_clear |=> overflow_flag)
      else $error("flag lost");
   ppg_restart_a: assert property (hit_a && op_mode == 2'h3 |=> count_reg == '0)
      else $error("ppg clear");
   stop_zero_a: assert property (op_mode == 2'h0 |=> count_reg == '0) else $error("stop");
   capture_b_a: assert property (op_mode != 2'h0 && cc_b_is_capture &&
      trig_a_edge_sel == 2'h1 && $rose(trigger_in_a) |=>
      capture_compare_b == $past(count_reg) && match_irq_b) else $error("B capture");
   cover property (op_mode == 2'h3 && $rose(timer_out));
   cover property ($rose(overflow_flag));
   cover property (cc_b_is_capture && match_irq_b);
endmodule : tccp_timer_assertions

bind tccp_timer tccp_timer_assertions #(.CNT_W(CNT_W)) chk (.clock, .resetn, .count_tick,
   .op_mode, .cc_a_is_capture, .cc_b_is_capture, .trig_a_edge_sel, .trigger_in_a,
   .overflow_clear, .count_reg, .capture_compare_a, .capture_compare_b, .match_irq_a,
   .match_irq_b, .overflow_flag, .timer_out);

// ==== sim/tccp_pins.sv ====
// trigger sources standing outside the timer pins
`timescale 1ns/1ps
module tccp_pins (
   input wire logic clock,
   output logic trig_a,
   output logic trig_b
);
   initial begin
      trig_a = 1'h0;
      trig_b = 1'h0;
   end
   // pins are always driven, so a flip is one clean level change just after an edge
   task automatic flip(input bit on_b);
      @(posedge clock);
      #1;
      if (on_b) trig_b = ~trig_b;
      else trig_a = ~trig_a;
   endtask : flip
endmodule : tccp_pins

// ==== sim/tccp_timer_bench.sv ====
// self-checking bench for the timer block
`timescale 1ns/1ps
module tccp_timer_bench;
   logic clock = 1'h0, resetn = 1'h0, count_tick = 1'h1, cc_a_trig_sel = 1'h0;
   logic cc_a_is_capture = 1'h0, cc_b_is_capture = 1'h0, out_toggle_on_edge = 1'h0;
   logic out_enable = 1'h1, out_level_set = 1'h0, out_level_reset = 1'h0, lvl = 1'h0;
   logic toggle_on_match_a = 1'h0, toggle_on_match_b = 1'h0, overflow_clear = 1'h0;
   logic cc_a_wr = 1'h0, cc_b_wr = 1'h0;
   tccp_pkg::tccp_mode_t op_mode = 2'h0;
   tccp_pkg::tccp_edge_sel_t trig_a_edge_sel = 2'h1, trig_b_edge_sel = 2'h3;
   logic [15:0] cc_a_wdata = 16'h0000, cc_b_wdata = 16'h0000;
   logic [15:0] count_reg, capture_compare_a, capture_compare_b;
   logic trigger_in_a, trigger_in_b, match_irq_a, match_irq_b, overflow_flag, timer_out;
   int num_errors = 0, tests_run = 0, cyc = 0, ia, ib, chg, hi;
   // mode tog a b cycles | irq_a irq_b out_changes out_high count
   int rows[7][10] = '{'{1, 3, 3, 5, 10, 1, 1, 2, 2, 10}, '{1, 2, 2, 6, 10, 1, 1, 1, 4, 10},
      '{1, 1, 2, 6, 10, 1, 1, 1, 8, 10}, '{1, 0, 2, 6, 10, 1, 1, 0, 0, 10},
      '{3, 0, 4, 1, 22, 4, 5, 8, 8, 2}, '{3, 3, 6, 2, 21, 3, 3, 5, 7, 0},
      '{0, 3, 0, 0, 6, 0, 0, 0, 0, 0}};
   always #2.5 clock = ~clock;
   tccp_timer DUT (.clock, .resetn, .count_tick, .op_mode, .cc_a_is_capture, .cc_b_is_capture,
      .cc_a_trig_sel, .trig_a_edge_sel, .trig_b_edge_sel, .trigger_in_a, .trigger_in_b,
      .out_toggle_on_edge, .out_enable, .toggle_on_match_a, .toggle_on_match_b,
      .out_level_set, .out_level_reset, .cc_a_wr, .cc_a_wdata, .cc_b_wr, .cc_b_wdata,
      .overflow_clear, .count_reg, .capture_compare_a, .capture_compare_b, .match_irq_a,
      .match_irq_b, .overflow_flag, .timer_out);
   tccp_pins pins (.clock, .trig_a(trigger_in_a), .trig_b(trigger_in_b));
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic step(input int n = 1);
      repeat (n) begin
         @(posedge clock);
         #1;
      end
   endtask : step
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   // stopped mode zeroes the count; level reset starts the output low
   task automatic setup(input int md, tg, a, b);
      op_mode = 2'h0;
      {toggle_on_match_b, toggle_on_match_a} = 2'(tg);
      cc_a_wdata = 16'(a);
      cc_b_wdata = 16'(b);
      {cc_a_wr, cc_b_wr, out_level_reset} = 3'h7;
      step();
      {cc_a_wr, cc_b_wr, out_level_reset} = 3'h0;
      op_mode = 2'(md);
      {ia, ib, chg, hi} = 128'h0;
      lvl = 1'h0;
   endtask : setup
   task automatic run(input int n);
      repeat (n) begin
         step();
         ia += (match_irq_a === 1'h1);
         ib += (match_irq_b === 1'h1);
         chg += (timer_out !== lvl);
         hi += (timer_out === 1'h1);
         lvl = timer_out;
      end
   endtask : run
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   // ----
   // main sequence
   // ----
   initial begin
      step(16);
      chk({count_reg, match_irq_a, match_irq_b, overflow_flag, timer_out}, 0);
      chk({capture_compare_a, capture_compare_b}, 0);
      resetn = 1'h1;
      $display("reset test done");
      foreach (rows[i]) begin
         setup(rows[i][0], rows[i][1], rows[i][2], rows[i][3]);
         run(rows[i][4]);
         chk(ia, rows[i][5]);
         chk(ib, rows[i][6]);
         chk(chg, rows[i][7]);
         chk(hi, rows[i][8]);
         chk(count_reg, rows[i][9]);
         $display("row %0d done", i);
      end
      setup(1, 0, 0, 0);
      run(65536);
      chk({overflow_flag, count_reg}, 17'h1_0000);
      run(5);
      chk(overflow_flag, 1);
      overflow_clear = 1'h1;
      step();
      overflow_clear = 1'h0;
      chk(overflow_flag, 0);
      count_tick = 1'h0;
      step(3);
      chk(count_reg, 6);
      count_tick = 1'h1;
      $display("overflow test done");
      setup(1, 3, 0, 0);
      {cc_a_is_capture, cc_b_is_capture, out_toggle_on_edge} = 3'h7;
      pins.flip(1);
      step();
      chk({capture_compare_a, capture_compare_b, match_irq_a}, {32'h0001_0000, 1'h1});
      pins.flip(1);
      step();
      chk({capture_compare_a, capture_compare_b}, 32'h0003_0000);
      pins.flip(0);
      step();
      chk({capture_compare_b, match_irq_b, timer_out}, {16'h0005, 2'h2});
      {cc_a_trig_sel, trig_b_edge_sel} = 3'h6;
      pins.flip(0);
      step();
      chk({capture_compare_a, timer_out}, {16'h0007, 1'h0});
      pins.flip(0);
      step();
      chk({capture_compare_b, timer_out}, {16'h0009, 1'h1});
      {op_mode, trig_a_edge_sel} = 4'h8;
      pins.flip(0);
      step();
      chk({count_reg, capture_compare_b}, 32'h0000_000b);
      $display("capture test done");
      // disabled pin stays low through whole periods; level set then re-arms it
      {cc_a_is_capture, cc_b_is_capture, out_toggle_on_edge, out_enable} = 4'h0;
      setup(3, 0, 4, 1);
      run(10);
      chk(chg, 0);
      chk(ia, 2);
      {out_enable, out_level_set} = 2'h3;
      step();
      chk(timer_out, 1);
      out_level_set = 1'h0;
      step();
      chk(timer_out, 0);
      $display("output enable test done");
      conclude();
   end
endmodule : tccp_timer_bench
